// ==== hw/iseq_seq.sv ====
// Single-master two-wire byte sequencer: start, address, data bytes, stop.
// Assumes pull-ups on both lines, one master, and a local controller on clk.
`include "iseq_params.svh"

module iseq_seq #(
  parameter int HALF_CYC = `ISEQ_HALF_CYC,
  parameter int SDA_DLY  = `ISEQ_SDA_DLY_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 start_req,
  input  wire iseq_pkg::iseq_req_s  req,
  input  wire logic [7:0]           tx_data,
  output logic [7:0]                byte_count_ff,
  output logic [7:0]                rx_data_ff,
  output logic                      rx_valid_ff,
  output logic [7:0]                rx_ptr_ff,
  output logic                      byte_evt_ff,
  output iseq_pkg::iseq_status_s    status_ff,
  input  wire logic                 scl_i,
  output logic                      scl_o_ff,
  output logic                      scl_oe_ff,
  input  wire logic                 sda_i,
  output logic                      sda_o_ff,
  output logic                      sda_oe_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [7:0] DLY     = 8'(SDA_DLY);

  if (HALF_CYC < SDA_DLY + 2 || HALF_CYC > 255 || SDA_DLY < 1) begin : g_bad_timing
    $error("iseq_seq: half period must exceed the data delay and fit eight bits");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line synchronisers

  logic scl_m_ff;
  logic scl_s_ff;
  logic sda_m_ff;
  logic sda_s_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decision at the acknowledge point

  iseq_pkg::iseq_state_e state_ff;
  logic [7:0]            cnt_ff;
  logic [3:0]            bit_cnt_ff;
  logic [8:0]            tx_shift_ff;
  logic [8:0]            rx_shift_ff;
  logic [8:0]            rx_word_ff;
  logic                  tx_empty_ff;
  logic                  rw_ff;
  logic [7:0]            len_ff;
  logic                  stop_now;
  logic                  set_addr_err;
  logic                  set_nack_err;
  logic                  store_rx;
  logic                  load_next;
  logic                  addr_phase;
  logic                  bus_free;
  logic                  start_ok;
  logic                  par_bad;
  logic                  stop_seen;
  logic [7:0]            idx_inc;

  assign addr_phase = (byte_count_ff == `ISEQ_IDX_RST);
  assign bus_free   = scl_s_ff && sda_s_ff;
  assign start_ok   = (state_ff == iseq_pkg::S_IDLE) && start_req && (req.len != 8'h00)
                      && bus_free && !status_ff.busy;
  assign par_bad    = (state_ff == iseq_pkg::S_IDLE) && start_req && (req.len == 8'h00);
  assign stop_seen  = (state_ff == iseq_pkg::S_STOP_WAIT) && bus_free;
  assign idx_inc    = 8'(byte_count_ff + 8'h01);

  always_comb begin
    stop_now     = 1'b0;
    set_addr_err = 1'b0;
    set_nack_err = 1'b0;
    store_rx     = 1'b0;
    load_next    = 1'b0;
    if (state_ff == iseq_pkg::S_ACK) begin
      if (addr_phase && rx_word_ff[0] == `ISEQ_NACK_BIT) begin
        set_addr_err = 1'b1;
        stop_now     = 1'b1;
      end else if (!rw_ff) begin
        if (rx_word_ff[0] == `ISEQ_NACK_BIT) begin
          set_nack_err = 1'b1;
          stop_now     = 1'b1;
        end else if (byte_count_ff < len_ff) begin
          load_next = 1'b1;
        end else begin
          stop_now = 1'b1;
        end
      end else begin
        // Master answers its own data bytes, so the slave ack is not checked here
        store_rx = !addr_phase;
        if (byte_count_ff >= len_ff) begin
          stop_now = 1'b1;
        end else begin
          load_next = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit sequencer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff      <= iseq_pkg::S_IDLE;
      cnt_ff        <= 8'h00;
      bit_cnt_ff    <= 4'h0;
      tx_shift_ff   <= `ISEQ_SHIFT_IDLE;
      rx_shift_ff   <= 9'h0_00;
      rx_word_ff    <= 9'h0_00;
      tx_empty_ff   <= 1'b0;
      rw_ff         <= 1'b0;
      len_ff        <= 8'h00;
      byte_count_ff <= `ISEQ_IDX_RST;
      scl_oe_ff     <= 1'b0;
      sda_oe_ff     <= 1'b0;
      byte_evt_ff   <= 1'b0;
    end else begin
      byte_evt_ff <= 1'b0;
      tx_empty_ff <= 1'b0;
      case (state_ff)
        iseq_pkg::S_IDLE: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
          if (start_ok) begin
            rw_ff     <= req.rw;
            len_ff    <= req.len;
            sda_oe_ff <= 1'b1;
            cnt_ff    <= 8'h00;
            state_ff  <= iseq_pkg::S_START;
          end
        end
        iseq_pkg::S_START: begin
          cnt_ff <= 8'(cnt_ff + 8'h01);
          if (cnt_ff == HALF_M1) begin
            scl_oe_ff     <= 1'b1;
            cnt_ff        <= 8'h00;
            bit_cnt_ff    <= 4'h0;
            tx_shift_ff   <= {req.addr, req.rw, `ISEQ_NACK_BIT};
            byte_count_ff <= `ISEQ_IDX_RST;
            state_ff      <= iseq_pkg::S_LOW;
          end
        end
        iseq_pkg::S_LOW: begin
          cnt_ff <= 8'(cnt_ff + 8'h01);
          if (cnt_ff == DLY) begin
            sda_oe_ff <= ~tx_shift_ff[8];
          end
          if (cnt_ff == HALF_M1) begin
            scl_oe_ff <= 1'b0;
            cnt_ff    <= 8'h00;
            state_ff  <= iseq_pkg::S_HIGH;
          end
        end
        iseq_pkg::S_HIGH: begin
          if (!scl_s_ff) begin
            cnt_ff <= 8'h00;
          end else if (cnt_ff == HALF_M1) begin
            rx_shift_ff <= {rx_shift_ff[7:0], sda_s_ff};
            tx_shift_ff <= {tx_shift_ff[7:0], `ISEQ_NACK_BIT};
            scl_oe_ff   <= 1'b1;
            cnt_ff      <= 8'h00;
            if (bit_cnt_ff == 4'h8) begin
              rx_word_ff  <= {rx_shift_ff[7:0], sda_s_ff};
              tx_empty_ff <= 1'b1;
              byte_evt_ff <= 1'b1;
              state_ff    <= iseq_pkg::S_ACK;
            end else begin
              bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
              state_ff   <= iseq_pkg::S_LOW;
            end
          end else begin
            cnt_ff <= 8'(cnt_ff + 8'h01);
          end
        end
        iseq_pkg::S_ACK: begin
          cnt_ff     <= 8'h00;
          bit_cnt_ff <= 4'h0;
          if (stop_now) begin
            state_ff <= iseq_pkg::S_STOP_LOW;
          end else if (load_next) begin
            byte_count_ff <= idx_inc;
            if (rw_ff) begin
              // Data bits released; ninth bit carries our answer
              tx_shift_ff <= {`ISEQ_RX_FILL,
                              (idx_inc >= len_ff) ? `ISEQ_NACK_BIT : `ISEQ_ACK_BIT};
            end else begin
              tx_shift_ff <= {tx_data, `ISEQ_NACK_BIT};
            end
            state_ff <= iseq_pkg::S_LOW;
          end else begin
            state_ff <= iseq_pkg::S_STOP_LOW;
          end
        end
        iseq_pkg::S_STOP_LOW: begin
          cnt_ff <= 8'(cnt_ff + 8'h01);
          if (cnt_ff == DLY) begin
            sda_oe_ff <= 1'b1;
          end
          if (cnt_ff == HALF_M1) begin
            scl_oe_ff <= 1'b0;
            cnt_ff    <= 8'h00;
            state_ff  <= iseq_pkg::S_STOP_HIGH;
          end
        end
        iseq_pkg::S_STOP_HIGH: begin
          if (!scl_s_ff) begin
            cnt_ff <= 8'h00;
          end else if (cnt_ff == HALF_M1) begin
            sda_oe_ff <= 1'b0;
            cnt_ff    <= 8'h00;
            state_ff  <= iseq_pkg::S_STOP_WAIT;
          end else begin
            cnt_ff <= 8'(cnt_ff + 8'h01);
          end
        end
        iseq_pkg::S_STOP_WAIT: begin
          // A stop is only trusted once both lines read back high
          if (stop_seen) begin
            scl_oe_ff     <= 1'b0;
            sda_oe_ff     <= 1'b0;
            tx_shift_ff   <= `ISEQ_SHIFT_IDLE;
            byte_count_ff <= `ISEQ_IDX_RST;
            bit_cnt_ff    <= 4'h0;
            state_ff      <= iseq_pkg::S_IDLE;
          end
        end
        default: begin
          state_ff <= iseq_pkg::S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else begin
      // Level is always low; only the enables move, so no line is ever driven high
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive buffer port

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_ptr_ff   <= 8'h00;
    end else begin
      rx_valid_ff <= 1'b0;
      if (start_ok) begin
        rx_ptr_ff <= 8'h00;
      end else if (store_rx) begin
        rx_data_ff  <= rx_word_ff[8:1];
        rx_valid_ff <= 1'b1;
        rx_ptr_ff   <= 8'(rx_ptr_ff + 8'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion status

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ff <= '{busy: 1'b0, ready: 1'b1, addr_err: 1'b0, nack_err: 1'b0, par_err: 1'b0};
    end else begin
      if (start_ok) begin
        status_ff <= '{busy: 1'b1, ready: 1'b0, addr_err: 1'b0, nack_err: 1'b0,
                       par_err: 1'b0};
      end else if (par_bad) begin
        status_ff.par_err <= 1'b1;
      end
      if (set_addr_err) begin
        status_ff.addr_err <= 1'b1;
      end
      if (set_nack_err) begin
        status_ff.nack_err <= 1'b1;
      end
      if (stop_seen) begin
        status_ff.busy  <= 1'b0;
        status_ff.ready <= !status_ff.addr_err;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  evt_ninth_a: assert property (@(posedge clk) disable iff (rst)
    byte_evt_ff |-> $past(bit_cnt_ff) == 4'h8 && scl_oe_ff && state_ff == iseq_pkg::S_ACK)
    else $error("byte event not at end of ninth bit");

  capture_first_a: assert property (@(posedge clk) disable iff (rst)
    byte_evt_ff |-> rx_word_ff == rx_shift_ff && tx_empty_ff)
    else $error("acknowledge word not captured at event");

  addr_nack_a: assert property (@(posedge clk) disable iff (rst)
    set_addr_err |=> status_ff.addr_err && state_ff == iseq_pkg::S_STOP_LOW)
    else $error("address NACK did not flag and stop");

  stop_issue_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == iseq_pkg::S_STOP_LOW && cnt_ff == 8'h00 |-> ##[1:40] sda_oe_ff && !scl_oe_ff)
    else $error("stop condition not driven");

  tx_next_a: assert property (@(posedge clk) disable iff (rst)
    load_next && !rw_ff |=> tx_shift_ff == {$past(tx_data), 1'b1}
      && state_ff == iseq_pkg::S_LOW)
    else $error("next transmit byte not loaded");

  data_nack_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == iseq_pkg::S_ACK && !rw_ff && !addr_phase && rx_word_ff[0]
      |=> status_ff.nack_err && state_ff == iseq_pkg::S_STOP_LOW)
    else $error("data NACK did not flag and stop");

  rx_store_a: assert property (@(posedge clk) disable iff (rst)
    store_rx |=> rx_valid_ff && rx_data_ff == $past(rx_word_ff[8:1])
      && rx_ptr_ff == 8'($past(rx_ptr_ff) + 8'h01))
    else $error("received byte not stored");

  ack_preload_a: assert property (@(posedge clk) disable iff (rst)
    load_next && rw_ff |=> tx_shift_ff[0] == (byte_count_ff >= len_ff))
    else $error("wrong acknowledge preloaded");

  last_stop_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == iseq_pkg::S_ACK && rw_ff && !addr_phase && byte_count_ff >= len_ff
      |=> state_ff == iseq_pkg::S_STOP_LOW)
    else $error("no stop after last received byte");

  idle_restore_a: assert property (@(posedge clk) disable iff (rst)
    stop_seen |=> state_ff == iseq_pkg::S_IDLE && !status_ff.busy && !sda_oe_ff && !scl_oe_ff)
    else $error("idle settings not restored");

  sda_delay_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == iseq_pkg::S_LOW && $changed(sda_oe_ff) |-> cnt_ff == 8'(DLY + 8'h01))
    else $error("data line moved at wrong delay");

  stretch_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == iseq_pkg::S_HIGH && !scl_s_ff |=> cnt_ff == 8'h00 && !scl_oe_ff)
    else $error("clock high not measured from line");

endmodule : iseq_seq

// ==== hw/iseq_params.svh ====
// Constants for the single-master two-wire byte sequencer.
// Assumes the sequencer clock runs at 10 MHz and is the bit-rate count source.
`ifndef ISEQ_PARAMS_SVH
`define ISEQ_PARAMS_SVH

// Sequencer clock and nominal line rate
`define ISEQ_CLK_HZ       10000000
`define ISEQ_SCL_KBPS     378
// Half bit period in clock cycles, rounded down; the high half adds two synchroniser cycles, so the line runs below the nominal rate
`define ISEQ_HALF_CYC     (`ISEQ_CLK_HZ / (2 * `ISEQ_SCL_KBPS * 1000))
// Data line changes one more than this many count-source cycles after the clock falls
`define ISEQ_SDA_DLY_CYC  7
`define ISEQ_SDA_DLY_MAX  8

// Ninth-bit values and idle values
`define ISEQ_ACK_BIT      1'b0
`define ISEQ_NACK_BIT     1'b1
`define ISEQ_RX_FILL      8'hFF
`define ISEQ_IDX_RST      8'h00
`define ISEQ_SHIFT_IDLE   9'h1_FF

`endif

// ==== hw/iseq_pkg.sv ====
// Types shared by the byte sequencer and its users.
// Assumes iseq_params.svh carries all numeric constants.
package iseq_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_START,
    S_LOW,
    S_HIGH,
    S_ACK,
    S_STOP_LOW,
    S_STOP_HIGH,
    S_STOP_WAIT
  } iseq_state_e;

  typedef struct packed {
    logic       rw;
    logic [6:0] addr;
    logic [7:0] len;
  } iseq_req_s;

  typedef struct packed {
    logic busy;
    logic ready;
    logic addr_err;
    logic nack_err;
    logic par_err;
  } iseq_status_s;

endpackage : iseq_pkg

// ==== bench/iseq_slave.sv ====
// Behavioural two-wire slave that answers the byte sequencer.
// Assumes pull-ups on both lines; the bench resolves the wires from all enables.
module iseq_slave (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [6:0]  my_addr,
  input  wire logic [7:0]  nack_at,
  input  wire logic [7:0]  rd_base,
  input  wire logic        stretch,
  output logic             sda_oe,
  output logic             scl_oe,
  output logic [7:0]       addr_byte,
  output logic [63:0]      wr_log,
  output logic [7:0]       mack_log,
  output int               n_start,
  output int               n_stop
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] v;
  int         idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Stretch: hold the clock low so the master must wait on the line level
  task automatic hold_low;
    if (stretch) begin
      #1 scl_oe = 1'b1;
      #3000 scl_oe = 1'b0;
    end
  endtask : hold_low

  task automatic rx8(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      b[i] = sda;
    end
    @(negedge scl);
  endtask : rx8

  // Answer first, then the stretch, so data never moves while the clock is high
  task automatic ack9(input logic give);
    #200 sda_oe = give;
    hold_low();
    @(negedge scl);
    sda_oe = 1'b0;
  endtask : ack9

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sda_oe   = 1'b0;
    scl_oe   = 1'b0;
    wr_log   = '0;
    mack_log = '0;
    n_start  = 0;
    n_stop   = 0;
    forever begin
      @(negedge sda iff (scl === 1'b1));
      n_start++;
      begin : frame
        rx8(addr_byte);
        idx = 0;
        if (addr_byte[7:1] != my_addr) begin
          disable frame;
        end
        ack9(1'b1);
        if (addr_byte[0]) begin
          forever begin
            v = rd_base + idx[7:0];
            for (int i = 7; i >= 0; i--) begin
              #200 sda_oe = ~v[i];
              hold_low();
              @(negedge scl);
            end
            sda_oe = 1'b0;
            @(posedge scl);
            mack_log = {mack_log[6:0], sda};
            @(negedge scl);
            idx++;
            if (mack_log[0]) begin
              disable frame;
            end
          end
        end else begin
          forever begin
            rx8(v);
            wr_log = {wr_log[55:0], v};
            idx++;
            ack9(idx[7:0] != nack_at);
          end
        end
      end
      // Whatever ended the frame, both lines are let go
      sda_oe = 1'b0;
      scl_oe = 1'b0;
    end
  end

  // Stop ends any frame in progress and frees both lines
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stop++;
      disable frame;
    end
  end
endmodule : iseq_slave

// ==== bench/tb_top.sv ====
// Self-checking bench for the byte sequencer with a behavioural slave.
// Assumes default sequencer parameters and a 10 MHz clock.
`include "iseq_params.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, exp, got); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk, rst, start_req;
  iseq_pkg::iseq_req_s    req;
  logic [7:0]             tx_data, byte_count_ff, rx_data_ff, rx_ptr_ff;
  logic                   rx_valid_ff, byte_evt_ff;
  iseq_pkg::iseq_status_s status_ff;
  logic                   scl_o_ff, scl_oe_ff, sda_o_ff, sda_oe_ff;
  logic                   s_scl_oe, s_sda_oe, s_stretch, scl_w, sda_w;
  logic                   scl_q, soe_q, sdq;
  logic [6:0]             s_addr;
  logic [7:0]             s_nack_at, addr_byte, mack_log;
  logic [7:0]             rd_base;
  logic [63:0]            wr_log;
  int                     n_start, n_stop, n_errors, checks, n_rx, nf, lowcnt, n;
  int                     cyc = 0;
  logic [7:0]             cnt_seen;

  // Open-drain wires with pull-ups
  assign scl_w = ~(scl_oe_ff | s_scl_oe);
  assign sda_w = ~(sda_oe_ff | s_sda_oe);

  iseq_seq i_dut (.clk(clk), .rst(rst), .start_req(start_req), .req(req),
    .tx_data(tx_data), .byte_count_ff(byte_count_ff), .rx_data_ff(rx_data_ff),
    .rx_valid_ff(rx_valid_ff), .rx_ptr_ff(rx_ptr_ff), .byte_evt_ff(byte_evt_ff),
    .status_ff(status_ff), .scl_i(scl_w), .scl_o_ff(scl_o_ff), .scl_oe_ff(scl_oe_ff),
    .sda_i(sda_w), .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff));

  iseq_slave i_slv (.scl(scl_w), .sda(sda_w), .my_addr(s_addr), .nack_at(s_nack_at),
    .rd_base(rd_base), .stretch(s_stretch), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe),
    .addr_byte(addr_byte), .wr_log(wr_log), .mack_log(mack_log), .n_start(n_start),
    .n_stop(n_stop));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Byte for index k is 3C xor k, so each loaded byte is traceable
  always @(posedge clk) tx_data <= 8'h3C ^ byte_count_ff;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      $display("unexpected timeout exp 0 got %0d", cyc);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line monitor: clock falls, low-half lengths, data-line timing, receive data
  always @(posedge clk) begin
    if (start_req === 1'b1) nf = 0;
    else if (scl_q && !scl_w) nf++;
    scl_q = scl_w;
    // The decision cycle after each byte lengthens that low by one
    if (scl_oe_ff && !soe_q) lowcnt = (byte_evt_ff === 1'b1) ? -1 : 0;
    else lowcnt++;
    // Counter is cleared at stop, so keep its last value seen while busy
    if (status_ff.busy === 1'b1) cnt_seen = byte_count_ff;
    if (!scl_oe_ff && soe_q && status_ff.busy) `CHK("low half", `ISEQ_HALF_CYC, lowcnt)
    if (scl_oe_ff && sda_oe_ff !== sdq) `CHK("sda delay", 1'b1, lowcnt inside {7, 8})
    if (byte_evt_ff === 1'b1) begin
      `CHK("evt edge", 1'b1, nf > 1 && (nf - 1) % 9 == 0)
      `CHK("open drain", 2'b00, {scl_o_ff, sda_o_ff})
    end
    if (rx_valid_ff === 1'b1) begin
      `CHK("rx data", rd_base + n_rx[7:0], rx_data_ff)
      n_rx++;
    end
    soe_q = scl_oe_ff;
    sdq   = sda_oe_ff;
  end

  // One transfer: request, wait for busy to drop under a bound, check the stop
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] len,
                      input string nm);
    int n;
    int stops;
    stops = n_stop;
    n_rx  = 0;
    @(posedge clk);
    req       <= {rw, a, len};
    start_req <= 1'b1;
    @(posedge clk);
    start_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("busy", len != 0, status_ff.busy)
    n = 0;
    while (status_ff.busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    `CHK("done", 1'b0, status_ff.busy)
    `CHK("stops", stops + (len != 0), n_stop)
    `CHK("scl released", 1'b0, scl_oe_ff)
    `CHK("sda released", 1'b0, sda_oe_ff)
    `CHK("count cleared", 8'h00, byte_count_ff)
    $display("test %s done", nm);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst       = 1'b1;
    start_req = 1'b0;
    req       = '0;
    s_addr    = 7'h2A;
    s_nack_at = 8'h00;
    s_stretch = 1'b0;
    rd_base   = 8'hC5;
    n_errors  = 0;
    checks    = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("idle status", 5'b01000, status_ff)
    `CHK("idle lines", 2'b00, {scl_oe_ff, sda_oe_ff})

    // Write three bytes against a stretching slave
    s_stretch <= 1'b1;
    xfer(1'b0, 7'h2A, 8'h03, "write");
    `CHK("addr byte", 8'h54, addr_byte)
    `CHK("wr bytes", 24'h3C3D3E, wr_log[23:0])
    `CHK("wr status", 5'b01000, status_ff)
    `CHK("wr count", 8'h03, cnt_seen)
    s_stretch <= 1'b0;

    // Reads of one and three bytes: master acks all but the last
    for (int len = 1; len <= 3; len += 2) begin
      xfer(1'b1, 7'h2A, len[7:0], "read");
      `CHK("rd addr", 8'h55, addr_byte)
      `CHK("rx count", len, n_rx)
      `CHK("rx ptr", len[7:0], rx_ptr_ff)
      `CHK("master ack", 8'h01, mack_log & ((8'h01 << len) - 8'h01))
      `CHK("rd status", 5'b01000, status_ff)
    end

    // Nobody answers the address
    xfer(1'b0, 7'h15, 8'h02, "address nack");
    `CHK("addr err status", 5'b00100, status_ff)
    `CHK("addr err count", 8'h00, cnt_seen)

    // Slave refuses the second data byte
    s_nack_at <= 8'h02;
    xfer(1'b0, 7'h2A, 8'h04, "data nack");
    `CHK("nack status", 5'b01010, status_ff)
    `CHK("nack count", 8'h02, cnt_seen)
    `CHK("nack bytes", 16'h3C3D, wr_log[15:0])
    s_nack_at <= 8'h00;

    // Zero length is refused without touching the bus
    n = n_start;
    xfer(1'b0, 7'h2A, 8'h00, "zero length");
    `CHK("par err", 1'b1, status_ff.par_err)
    `CHK("no start", n, n_start)
    end_sim();
  end
endmodule : tb_top
